// ---- hdl/scs_flag_if.sv ----
// carrier between the register block and the line flag keeper
// assumes both ends run on sys_clk
interface scs_flag_if;
    logic overrun_ev;
    logic brk_frame;
    logic data_frame;
    logic cts_pin;
    logic [4:0] tx_free_cnt;
    logic tx_shift_empty;
    logic clr_overrun;
    logic clr_sticky;
    logic soft_init;
    logic [5:0] line_status;

    modport flags (
        input overrun_ev, brk_frame, data_frame, cts_pin, tx_free_cnt,
        input tx_shift_empty, clr_overrun, clr_sticky, soft_init,
        output line_status
    );
    modport ctrl (
        output overrun_ev, brk_frame, data_frame, cts_pin, tx_free_cnt,
        output tx_shift_empty, clr_overrun, clr_sticky, soft_init,
        input line_status
    );
endinterface

// ---- hdl/scs_line_flags.sv ----
// line condition flags of one serial channel
// assumes events are one-cycle pulses on sys_clk; cts_pin is asynchronous
module scs_line_flags
    import scs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // link to the register block
    scs_flag_if.flags bus
);
    logic cts_s1_q, cts_s2_q;
    logic [5:0] ls_q, ls_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ls_d = ls_q;
        // set wins over a write-zero clear in the same cycle
        ls_d[SCS_LS_OVERRUN] = bus.overrun_ev
            | (ls_q[SCS_LS_OVERRUN] & ~bus.clr_overrun);
        ls_d[SCS_LS_CTS] = cts_s2_q;
        if (bus.brk_frame) begin
            ls_d[SCS_LS_LIVE_BRK] = 1'b1;
        end else if (bus.data_frame) begin
            ls_d[SCS_LS_LIVE_BRK] = 1'b0;
        end
        ls_d[SCS_LS_TX_ROOM] = (bus.tx_free_cnt != 5'h00);
        ls_d[SCS_LS_ALL_SENT] = bus.tx_shift_empty
            & (bus.tx_free_cnt == 5'h10);
        ls_d[SCS_LS_STICKY_BRK] = bus.brk_frame
            | (ls_q[SCS_LS_STICKY_BRK] & ~bus.clr_sticky);
        if (bus.soft_init) begin
            ls_d = SCS_LS_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cts_s1_q <= 1'b0;
            cts_s2_q <= 1'b0;
            ls_q <= SCS_LS_RESET;
        end else begin
            cts_s1_q <= bus.cts_pin;
            cts_s2_q <= cts_s1_q;
            ls_q <= ls_d;
        end
    end

    assign bus.line_status = ls_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    overrun_set_a: assert property (
        bus.overrun_ev && !bus.soft_init |=> ls_q[SCS_LS_OVERRUN] [*1]
    ) else $error("overrun event not flagged");
    cts_level_a: assert property (
        !bus.soft_init ##1 1'b1 |-> ls_q[SCS_LS_CTS] == $past(bus.cts_pin, 3)
    ) else $error("cts level does not follow pin");
    live_brk_clear_a: assert property (
        bus.data_frame && !bus.brk_frame |=> !ls_q[SCS_LS_LIVE_BRK]
    ) else $error("live break not cleared by data frame");
    tx_room_a: assert property (
        !bus.soft_init |=> ls_q[SCS_LS_TX_ROOM]
            == ($past(bus.tx_free_cnt) != 5'h00)
    ) else $error("transmit room flag wrong");
    all_sent_a: assert property (
        !bus.tx_shift_empty |=> !ls_q[SCS_LS_ALL_SENT]
    ) else $error("all sent while shifter busy");
    sticky_hold_a: assert property (
        ls_q[SCS_LS_STICKY_BRK] && !bus.clr_sticky && !bus.soft_init
            |=> ls_q[SCS_LS_STICKY_BRK]
    ) else $error("sticky break lost");
endmodule

// ---- hdl/scs_pkg.sv ----
// constants, types and helpers shared by the serial channel status block
// assumes a single 25 MHz system clock with synchronous reset
package scs_pkg;
    // register byte addresses on the apb side
    localparam logic [15:0] SCS_ADDR_LINE_STATUS = 16'hf30c;
    localparam logic [15:0] SCS_ADDR_FIFO_CTRL = 16'hf310;
    localparam logic [15:0] SCS_ADDR_INT_STATUS = 16'hf330;
    localparam logic [15:0] SCS_ADDR_INT_MASK = 16'hf334;
    localparam logic [15:0] SCS_ADDR_CHG_SELECT = 16'hf338;
    // line_change_status fields
    localparam int SCS_LS_OVERRUN = 5;
    localparam int SCS_LS_CTS = 4;
    localparam int SCS_LS_LIVE_BRK = 3;
    localparam int SCS_LS_TX_ROOM = 2;
    localparam int SCS_LS_ALL_SENT = 1;
    localparam int SCS_LS_STICKY_BRK = 0;
    localparam int SCS_LS_WIDTH = 6;
    localparam logic [5:0] SCS_LS_RESET = 6'h06;
    // fifo_control fields
    localparam int SCS_FC_SOFT_RESET = 15;
    localparam int SCS_FC_RX_THR = 7;
    localparam int SCS_FC_TX_THR = 3;
    localparam int SCS_FC_TX_CLEAR = 2;
    localparam int SCS_FC_RX_CLEAR = 1;
    localparam int SCS_FC_CLEAR_EN = 0;
    localparam logic [1:0] SCS_THR_RESET = 2'h0;
    localparam logic SCS_CLEAR_RESET = 1'b0;
    // interrupt status and mask fields
    localparam int SCS_INT_RX_REQ = 0;
    localparam int SCS_INT_TX_REQ = 1;
    localparam int SCS_INT_STATUS_CHG = 2;
    localparam int SCS_INT_WIDTH = 3;
    localparam logic [2:0] SCS_INT_RESET = 3'h0;
    localparam logic [5:0] SCS_SEL_RESET = 6'h00;
    // fifo geometry
    localparam int SCS_CNT_WIDTH = 5;
    // channel initialisation time after a soft reset request
    localparam int SCS_CLK_PERIOD_NS = 40;
    localparam int SCS_SOFT_RESET_NS = 160;
    localparam int SCS_SOFT_RESET_CYCLES =
        (SCS_SOFT_RESET_NS + SCS_CLK_PERIOD_NS - 1) / SCS_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SCS_RUN = 2'b00,
        SCS_INIT = 2'b01
    } scs_state_t;

    function automatic logic [4:0] scs_rx_level(input logic [1:0] code);
        case (code)
            2'h0: scs_rx_level = 5'h01;
            2'h1: scs_rx_level = 5'h04;
            2'h2: scs_rx_level = 5'h08;
            default: scs_rx_level = 5'h0c;
        endcase
    endfunction

    // code 3 is forbidden; it yields zero, which the caller treats as off
    function automatic logic [4:0] scs_tx_level(input logic [1:0] code);
        case (code)
            2'h0: scs_tx_level = 5'h01;
            2'h1: scs_tx_level = 5'h04;
            2'h2: scs_tx_level = 5'h08;
            default: scs_tx_level = 5'h00;
        endcase
    endfunction
endpackage

// ---- hdl/scs_top.sv ----
// status reporting and fifo control for one serial channel, apb slave
// assumes fifo counts and frame events come from logic on sys_clk;
// cts_pin comes straight from the pad
//
// What this block does
// - overrun flag bit 5 sets on overrun, clears only by writing zero or soft reset.
// - bit 4 reads the clear-to-send pin level, read only.
// - live break bit 3 sets on break, clears on a non-break frame.
// - transmit room bit 2 is one while the transmit fifo has space.
// - all sent bit 1 is one only when transmit fifo and shifter are empty or a soft reset runs.
// - sticky break bit 0 sets on break, holds until written zero or soft reset.
// - soft reset bit 15 reinitialises channel, reads one until done.
// - receive threshold bits 8:7 select 1, 4, 8 or 12 bytes.
// - transmit threshold bits 4:3 select 1, 4, 8; code 11 forbidden.
// - transmit fifo clear bit 2 empties and holds fifo when enabled.
// - receive fifo clear bit 1 empties and holds fifo when enabled.
// - clear enable bit 0 gates both fifo clear bits.
// - receive request raises once fifo holds threshold bytes or more.
// - transmit request raises once free space reaches threshold.
// - status change flag sets when a selected status bit rises.
module scs_top
    import scs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line and receiver events
    input wire logic cts_pin,
    input wire logic overrun_event,
    input wire logic break_frame,
    input wire logic data_frame,
    // fifo and shifter state
    input wire logic [4:0] tx_free_count,
    input wire logic [4:0] rx_count,
    input wire logic tx_shift_empty,
    // controls to the channel
    output logic tx_fifo_clear,
    output logic rx_fifo_clear,
    output logic channel_init,
    output logic rx_request,
    output logic tx_request,
    output logic irq
);
    import scs_pkg::*;

    function automatic logic addr_is(input logic [15:0] a,
                                     input logic [15:0] reg_addr);
        addr_is = (a == reg_addr);
    endfunction

    scs_flag_if flag_bus();

    scs_line_flags scs_line_flags_i (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(flag_bus.flags)
    );

    logic wr_en, rd_take, ready_d, err_d;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    scs_state_t state_q, state_d;
    logic [2:0] init_cnt_q, init_cnt_d;
    logic [1:0] rx_thr_q, rx_thr_d, tx_thr_q, tx_thr_d;
    logic tx_clr_q, tx_clr_d, rx_clr_q, rx_clr_d, clr_en_q, clr_en_d;
    logic [5:0] sel_q, sel_d, ls_prev_q;
    logic [2:0] int_mask_q, int_mask_d, int_st_q, int_st_d;
    logic rx_req_d, tx_req_d;
    logic rx_req_q, tx_req_q, irq_q, init_q;
    logic tx_fclr_q, rx_fclr_q;
    logic [5:0] ls;
    logic [31:0] fc_view;

    assign ls = flag_bus.line_status;

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: one wait state, every answer comes from flops
    assign wr_en = psel & penable & pready_q & pwrite;
    assign ready_d = psel & penable & ~pready_q;
    assign rd_take = ready_d & ~pwrite;

    always_comb begin
        fc_view = 32'h0;
        fc_view[SCS_FC_SOFT_RESET] = (state_q == SCS_INIT);
        fc_view[SCS_FC_RX_THR +: 2] = rx_thr_q;
        fc_view[SCS_FC_TX_THR +: 2] = tx_thr_q;
        fc_view[SCS_FC_TX_CLEAR] = tx_clr_q;
        fc_view[SCS_FC_RX_CLEAR] = rx_clr_q;
        fc_view[SCS_FC_CLEAR_EN] = clr_en_q;
    end

    always_comb begin
        rdata_d = 32'h0;
        err_d = 1'b0;
        if (addr_is(paddr, SCS_ADDR_LINE_STATUS)) begin
            rdata_d = {26'h0, ls};
        end else if (addr_is(paddr, SCS_ADDR_FIFO_CTRL)) begin
            rdata_d = fc_view;
        end else if (addr_is(paddr, SCS_ADDR_INT_STATUS)) begin
            rdata_d = {29'h0, int_st_q};
        end else if (addr_is(paddr, SCS_ADDR_INT_MASK)) begin
            rdata_d = {29'h0, int_mask_q};
        end else if (addr_is(paddr, SCS_ADDR_CHG_SELECT)) begin
            rdata_d = {26'h0, sel_q};
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= ready_d;
            pslverr_q <= ready_d & err_d;
            prdata_q <= rd_take ? rdata_d : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write-zero clears of the line flags; a one leaves them alone
    assign flag_bus.clr_overrun = wr_en
        & addr_is(paddr, SCS_ADDR_LINE_STATUS)
        & ~pwdata[SCS_LS_OVERRUN];
    assign flag_bus.clr_sticky = wr_en
        & addr_is(paddr, SCS_ADDR_LINE_STATUS)
        & ~pwdata[SCS_LS_STICKY_BRK];
    assign flag_bus.soft_init = (state_q == SCS_INIT);
    assign flag_bus.overrun_ev = overrun_event;
    assign flag_bus.brk_frame = break_frame;
    assign flag_bus.data_frame = data_frame;
    assign flag_bus.cts_pin = cts_pin;
    assign flag_bus.tx_free_cnt = tx_free_count;
    assign flag_bus.tx_shift_empty = tx_shift_empty;

    ////////////////////////////////////////////////////////////////////////
    // soft reset sequencer and control registers
    always_comb begin
        state_d = state_q;
        init_cnt_d = init_cnt_q;
        rx_thr_d = rx_thr_q;
        tx_thr_d = tx_thr_q;
        tx_clr_d = tx_clr_q;
        rx_clr_d = rx_clr_q;
        clr_en_d = clr_en_q;
        sel_d = sel_q;
        int_mask_d = int_mask_q;
        case (state_q)
            SCS_RUN: begin
                if (wr_en && addr_is(paddr, SCS_ADDR_FIFO_CTRL)) begin
                    rx_thr_d = pwdata[SCS_FC_RX_THR +: 2];
                    // forbidden code 3 is stored but raises no request
                    tx_thr_d = pwdata[SCS_FC_TX_THR +: 2];
                    tx_clr_d = pwdata[SCS_FC_TX_CLEAR];
                    rx_clr_d = pwdata[SCS_FC_RX_CLEAR];
                    clr_en_d = pwdata[SCS_FC_CLEAR_EN];
                    if (pwdata[SCS_FC_SOFT_RESET]) begin
                        state_d = SCS_INIT;
                        init_cnt_d = 3'(SCS_SOFT_RESET_CYCLES - 1);
                    end
                end
                if (wr_en && addr_is(paddr, SCS_ADDR_CHG_SELECT)) begin
                    sel_d = pwdata[5:0];
                end
                if (wr_en && addr_is(paddr, SCS_ADDR_INT_MASK)) begin
                    int_mask_d = pwdata[2:0];
                end
            end
            SCS_INIT: begin
                // fifo clear bits survive so the buffers stay untouched
                rx_thr_d = SCS_THR_RESET;
                tx_thr_d = SCS_THR_RESET;
                sel_d = SCS_SEL_RESET;
                int_mask_d = SCS_INT_RESET;
                if (init_cnt_q == 3'h0) begin
                    state_d = SCS_RUN;
                end else begin
                    init_cnt_d = init_cnt_q - 3'h1;
                end
            end
            default: begin
                state_d = SCS_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= SCS_RUN;
            init_cnt_q <= 3'h0;
            rx_thr_q <= SCS_THR_RESET;
            tx_thr_q <= SCS_THR_RESET;
            tx_clr_q <= SCS_CLEAR_RESET;
            rx_clr_q <= SCS_CLEAR_RESET;
            clr_en_q <= SCS_CLEAR_RESET;
            sel_q <= SCS_SEL_RESET;
            int_mask_q <= SCS_INT_RESET;
        end else begin
            state_q <= state_d;
            init_cnt_q <= init_cnt_d;
            rx_thr_q <= rx_thr_d;
            tx_thr_q <= tx_thr_d;
            tx_clr_q <= tx_clr_d;
            rx_clr_q <= rx_clr_d;
            clr_en_q <= clr_en_d;
            sel_q <= sel_d;
            int_mask_q <= int_mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // requests, status change detection and the interrupt
    always_comb begin
        rx_req_d = (rx_count >= scs_rx_level(rx_thr_q));
        tx_req_d = (scs_tx_level(tx_thr_q) != 5'h00)
            && (tx_free_count >= scs_tx_level(tx_thr_q));
        int_st_d = int_st_q;
        if (wr_en && addr_is(paddr, SCS_ADDR_INT_STATUS)) begin
            int_st_d = int_st_q & ~pwdata[2:0];
        end
        if (state_q == SCS_INIT) begin
            int_st_d = SCS_INT_RESET;
        end
        // set wins over a write-one clear in the same cycle
        int_st_d[SCS_INT_RX_REQ] = int_st_d[SCS_INT_RX_REQ]
            | (rx_req_d & ~rx_req_q);
        int_st_d[SCS_INT_TX_REQ] = int_st_d[SCS_INT_TX_REQ]
            | (tx_req_d & ~tx_req_q);
        int_st_d[SCS_INT_STATUS_CHG] = int_st_d[SCS_INT_STATUS_CHG]
            | (|(ls & ~ls_prev_q & sel_q));
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_st_q <= SCS_INT_RESET;
            ls_prev_q <= SCS_LS_RESET;
            rx_req_q <= 1'b0;
            tx_req_q <= 1'b0;
            irq_q <= 1'b0;
            init_q <= 1'b0;
            tx_fclr_q <= 1'b0;
            rx_fclr_q <= 1'b0;
        end else begin
            int_st_q <= int_st_d;
            ls_prev_q <= ls;
            rx_req_q <= rx_req_d;
            tx_req_q <= tx_req_d;
            irq_q <= |(int_st_d & int_mask_d);
            init_q <= (state_d == SCS_INIT);
            tx_fclr_q <= tx_clr_d & clr_en_d;
            rx_fclr_q <= rx_clr_d & clr_en_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_fifo_clear = tx_fclr_q;
    assign rx_fifo_clear = rx_fclr_q;
    assign channel_init = init_q;
    assign rx_request = rx_req_q;
    assign tx_request = tx_req_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence soft_start_s;
        $rose(state_q == SCS_INIT);
    endsequence
    sequence soft_body_s;
        (state_q == SCS_INIT) [*4] ##1 (state_q == SCS_RUN);
    endsequence

    soft_reset_len_a: assert property (
        soft_start_s |-> soft_body_s
    ) else $error("soft reset length wrong");
    soft_bit_read_a: assert property (
        rd_take && addr_is(paddr, SCS_ADDR_FIFO_CTRL) && state_q == SCS_INIT
            |=> prdata[SCS_FC_SOFT_RESET]
    ) else $error("soft reset bit not read as one");
    rx_req_level_a: assert property (
        rx_thr_q == 2'h3 && rx_count == 5'h0b |=> !rx_request
    ) else $error("receive request below twelve bytes");
    tx_forbid_a: assert property (
        tx_thr_q == 2'h3 |=> !tx_request
    ) else $error("transmit request on forbidden code");
    tx_clear_a: assert property (
        tx_clr_q && clr_en_q |-> tx_fifo_clear
    ) else $error("transmit fifo clear not applied");
    rx_clear_a: assert property (
        rx_clr_q && clr_en_q |-> rx_fifo_clear
    ) else $error("receive fifo clear not applied");
    clear_gate_a: assert property (
        !clr_en_q |-> !tx_fifo_clear && !rx_fifo_clear
    ) else $error("fifo cleared without enable");
    rx_req_a: assert property (
        rx_count >= scs_rx_level(rx_thr_q) |=> rx_request
    ) else $error("receive request missing");
    tx_req_a: assert property (
        tx_thr_q != 2'h3 && tx_free_count >= scs_tx_level(tx_thr_q)
            |=> tx_request
    ) else $error("transmit request missing");
    status_chg_a: assert property (
        |(ls & ~ls_prev_q & sel_q) |=> int_st_q[SCS_INT_STATUS_CHG]
    ) else $error("status change flag missing");
    reserved_zero_a: assert property (
        rd_take && addr_is(paddr, SCS_ADDR_FIFO_CTRL)
            |=> prdata[31:16] == 16'h0 && prdata[14:9] == 6'h00
    ) else $error("reserved bits not zero");
    apb_wait_a: assert property (
        psel && penable && !pready |=> pready
    ) else $error("apb answer late");
endmodule

// ---- tb/scs_line_model.sv ----
// far side of one serial channel: receiver events, cts pad, fifo levels
// assumes the bench calls its tasks; all changes land just after sys_clk
module scs_line_model (
    // clock
    input wire logic sys_clk,
    // fifo clear controls from the block
    input wire logic tx_fifo_clear,
    input wire logic rx_fifo_clear,
    // line and fifo state towards the block
    output logic cts_pin,
    output logic overrun_event,
    output logic break_frame,
    output logic data_frame,
    output logic [4:0] tx_free_count,
    output logic [4:0] rx_count,
    output logic tx_shift_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] tx_free_q = 5'h10;
    logic [4:0] rx_q = 5'h00;
    initial begin
        cts_pin = 1'b0;
        overrun_event = 1'b0;
        break_frame = 1'b0;
        data_frame = 1'b0;
        tx_shift_empty = 1'b1;
    end
    // a fifo held clear reads empty at once
    assign tx_free_count = tx_fifo_clear ? 5'h10 : tx_free_q;
    assign rx_count = rx_fifo_clear ? 5'h00 : rx_q;
    ////////////////////////////////////////////////////////////////////
    // kind 0 overrun, 1 break frame, 2 ordinary frame; one cycle each
    task automatic pulse(input logic [1:0] kind);
        @(posedge sys_clk);
        overrun_event <= (kind == 2'h0);
        break_frame <= (kind == 2'h1);
        data_frame <= (kind == 2'h2);
        @(posedge sys_clk);
        overrun_event <= 1'b0;
        break_frame <= 1'b0;
        data_frame <= 1'b0;
    endtask
    task automatic set_line(input logic cts, input logic [4:0] tx_free,
                            input logic [4:0] rx, input logic sh_empty);
        @(posedge sys_clk);
        cts_pin <= cts;
        tx_free_q <= tx_free;
        rx_q <= rx;
        tx_shift_empty <= sh_empty;
        // cts needs two sync stages and the flag stage before a read sees it
        repeat (2) @(posedge sys_clk);
    endtask
endmodule

// ---- tb/serial_port_status_and_fifo_control_tb_top.sv ----
// self-checking bench for the serial channel status block
// assumes scs_pkg, the design files and the line model are compiled first
module serial_port_status_and_fifo_control_tb_top
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, cts_pin, overrun_event, break_frame;
    logic data_frame, tx_shift_empty, tx_fifo_clear, rx_fifo_clear;
    logic channel_init, rx_request, tx_request, irq;
    logic [4:0] tx_free_count, rx_count;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int lvl_tab[4] = '{1, 4, 8, 12};

    always #20 sys_clk = ~sys_clk;

    scs_top scs_top_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cts_pin(cts_pin),
        .overrun_event(overrun_event), .break_frame(break_frame),
        .data_frame(data_frame), .tx_free_count(tx_free_count),
        .rx_count(rx_count), .tx_shift_empty(tx_shift_empty),
        .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear),
        .channel_init(channel_init), .rx_request(rx_request),
        .tx_request(tx_request), .irq(irq));

    scs_line_model scs_line_model_i (.sys_clk(sys_clk),
        .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear),
        .cts_pin(cts_pin), .overrun_event(overrun_event),
        .break_frame(break_frame), .data_frame(data_frame),
        .tx_free_count(tx_free_count), .rx_count(rx_count),
        .tx_shift_empty(tx_shift_empty));

    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a hung handshake would otherwise stall the run for good
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // setup, access until pready; data taken at the pready edge
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp,
                          input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(SCS_ADDR_LINE_STATUS, 32'h06, "ls reset");
        rd_chk(SCS_ADDR_FIFO_CTRL, 32'h0, "fc reset");
        scs_line_model_i.pulse(2'h0);
        scs_line_model_i.pulse(2'h1);
        rd_chk(SCS_ADDR_LINE_STATUS, 32'h2f, "ls ev");
        apb(1'b1, SCS_ADDR_LINE_STATUS, 32'hffffffff);
        rd_chk(SCS_ADDR_LINE_STATUS, 32'h2f, "ls ones");
        scs_line_model_i.pulse(2'h2);
        rd_chk(SCS_ADDR_LINE_STATUS, 32'h27, "ls frame");
        apb(1'b1, SCS_ADDR_LINE_STATUS, 32'h0);
        rd_chk(SCS_ADDR_LINE_STATUS, 32'h06, "ls w0");
        apb(1'b0, 16'hf3fc, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        // every writable bit but the soft reset, legal transmit code
        apb(1'b1, SCS_ADDR_FIFO_CTRL, 32'hffff7fef);
        rd_chk(SCS_ADDR_FIFO_CTRL, 32'h18f, "fc rsvd");
        chk("clears on", 32'h3,
            {30'h0, tx_fifo_clear, rx_fifo_clear});
        apb(1'b1, SCS_ADDR_FIFO_CTRL, 32'h6);
        repeat (2) @(posedge sys_clk);
        chk("clears gated", 32'h0,
            {30'h0, tx_fifo_clear, rx_fifo_clear});
        scs_line_model_i.set_line(1'b1, 5'h00, 5'h00, 1'b0);
        rd_chk(SCS_ADDR_LINE_STATUS, 32'h10, "ls full");
        scs_line_model_i.set_line(1'b1, 5'h10, 5'h00, 1'b0);
        rd_chk(SCS_ADDR_LINE_STATUS, 32'h14, "ls shift");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, SCS_ADDR_FIFO_CTRL, 32'(c) << 7);
            scs_line_model_i.set_line(1'b0, 5'h10, 5'(lvl_tab[c] - 1), 1'b1);
            repeat (3) @(posedge sys_clk);
            chk("rx req below", 32'h0, {31'h0, rx_request});
            scs_line_model_i.set_line(1'b0, 5'h10, 5'(lvl_tab[c]), 1'b1);
            repeat (3) @(posedge sys_clk);
            chk("rx req at", 32'h1, {31'h0, rx_request});
        end
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, SCS_ADDR_FIFO_CTRL, 32'(c) << 3);
            scs_line_model_i.set_line(1'b0, 5'(lvl_tab[c] - 1), 5'h0, 1'b0);
            repeat (3) @(posedge sys_clk);
            chk("tx req below", 32'h0, {31'h0, tx_request});
            scs_line_model_i.set_line(1'b0, 5'(lvl_tab[c]), 5'h0, 1'b0);
            repeat (3) @(posedge sys_clk);
            chk("tx req at", 32'h1, {31'h0, tx_request});
        end
        scs_line_model_i.set_line(1'b0, 5'h10, 5'h00, 1'b1);
        apb(1'b1, SCS_ADDR_INT_STATUS, 32'h7);
        apb(1'b1, SCS_ADDR_CHG_SELECT, 32'h20);
        apb(1'b1, SCS_ADDR_INT_MASK, 32'h4);
        scs_line_model_i.pulse(2'h0);
        rd_chk(SCS_ADDR_INT_STATUS, 32'h4, "int chg");
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, SCS_ADDR_INT_MASK, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, SCS_ADDR_INT_MASK, 32'h4);
        apb(1'b1, SCS_ADDR_INT_STATUS, 32'h4);
        rd_chk(SCS_ADDR_INT_STATUS, 32'h0, "int cleared");
        chk("irq off", 32'h0, {31'h0, irq});
        // soft reset with clears armed: fifo state must survive it
        apb(1'b1, SCS_ADDR_FIFO_CTRL, 32'h8187);
        apb(1'b0, SCS_ADDR_FIFO_CTRL, 32'h0);
        chk("sr busy", 32'h1, {31'h0, rd[15]});
        chk("sr init", 32'h1, {31'h0, channel_init});
        while (channel_init !== 1'b0) @(posedge sys_clk);
        rd_chk(SCS_ADDR_FIFO_CTRL, 32'h7, "sr done");
        chk("sr fifo kept", 32'h1, {31'h0, tx_fifo_clear});
        rd_chk(SCS_ADDR_LINE_STATUS, 32'h06, "sr ls");
        rd_chk(SCS_ADDR_INT_MASK, 32'h0, "sr mask");
        report_and_stop();
    end
endmodule
